// File: design/flash_cmd_pkg.sv
package flash_cmd_pkg;
	// Opcodes
	localparam logic [7:0] OP_ID_READ = 8'h9F;
	localparam logic [7:0] OP_STATUS = 8'hD7;
	localparam logic [7:0] OP_PAGE_READ = 8'hD2;
	localparam logic [7:0] OP_CONT_LF = 8'h03;
	localparam logic [7:0] OP_CONT_HF = 8'h0B;
	localparam logic [7:0] OP_CONT_LEGACY = 8'hE8;
	localparam logic [7:0] OP_BUF1_RD_LF = 8'hD1;
	localparam logic [7:0] OP_BUF2_RD_LF = 8'hD3;
	localparam logic [7:0] OP_BUF1_RD = 8'hD4;
	localparam logic [7:0] OP_BUF2_RD = 8'hD6;
	localparam logic [7:0] OP_BUF1_PROG_ERASE = 8'h83;
	localparam logic [7:0] OP_BUF2_PROG_ERASE = 8'h86;
	localparam logic [7:0] OP_BUF1_PROG_NOERASE = 8'h88;
	localparam logic [7:0] OP_BUF2_PROG_NOERASE = 8'h89;
	localparam logic [7:0] OP_PROG_THRU_BUF1 = 8'h82;
	localparam logic [7:0] OP_PROG_THRU_BUF2 = 8'h85;
	localparam logic [7:0] OP_BUF1_WRITE = 8'h84;
	localparam logic [7:0] OP_BUF2_WRITE = 8'h87;
	localparam logic [7:0] OP_PAGE_ERASE = 8'h81;
	localparam logic [7:0] OP_BLOCK_ERASE = 8'h50;
	localparam logic [7:0] OP_SECTOR_ERASE = 8'h7C;
	localparam logic [7:0] OP_CHIP_ERASE = 8'hC7;
	localparam logic [7:0] OP_XFER_BUF1 = 8'h53;
	localparam logic [7:0] OP_XFER_BUF2 = 8'h55;
	localparam logic [7:0] OP_CMP_BUF1 = 8'h60;
	localparam logic [7:0] OP_CMP_BUF2 = 8'h61;
	localparam logic [7:0] OP_REWRITE_BUF1 = 8'h58;
	localparam logic [7:0] OP_REWRITE_BUF2 = 8'h59;
	localparam logic [7:0] OP_PROT_PREFIX = 8'h3D;
	localparam logic [7:0] OP_SECURITY_PROG = 8'h9B;
	localparam logic [7:0] OP_RD_PROT = 8'h32;
	localparam logic [7:0] OP_RD_LOCK = 8'h35;
	localparam logic [7:0] OP_RD_SECURITY = 8'h77;
	// Identification values
	localparam logic [7:0] MAKER_CODE = 8'h5A; // Arbitrary value
	localparam logic [2:0] FAMILY_CODE = 3'h2; // Arbitrary value
	localparam logic [4:0] DENSITY_CODE = 5'h0A; // Arbitrary value
	localparam logic [2:0] CELL_TECH = 3'h1; // Arbitrary value
	localparam logic [4:0] PRODUCT_VERSION = 5'h03; // Arbitrary value
	localparam logic [7:0] EXT_INFO_LEN = 8'h00;
	localparam int ID_BYTES = 4;
	localparam logic [2:0] BIT_LAST = 3'h7;
	localparam logic [1:0] ID_LAST = 2'h3;
	localparam int STATUS_READY_BIT = 7;

	// Command classes
	typedef enum logic [2:0] {
		CLS_NONE, CLS_ARRAY_READ, CLS_PROG_ERASE, CLS_BUFFER,
		CLS_PROTECT
	} cmd_class_t;

	// Decoded command handed to the core domain
	typedef struct packed {
		logic [7:0] opcode;
		cmd_class_t cls;
		logic buf_two;
		logic erase_first;
	} cmd_info_t;

	// Busy status handed to the link domain
	typedef struct packed {
		logic busy;
		cmd_class_t busy_cls;
	} busy_info_t;
endpackage

// File: design/flash_cmd_core.sv
`timescale 1ns/1ns
module flash_cmd_core #(
	parameter int BUSY_CYCLES = 1000
) (
	input wire logic clk,
	input wire logic resetn,
	input wire logic clk_en,
	input wire logic sck,
	input wire logic cs_n,
	input wire logic si,
	output logic so,
	output logic so_oe,
	input wire logic [5:0] status_low,
	output flash_cmd_pkg::cmd_info_t cmd_info,
	output logic cmd_valid,
	output logic cmd_reject,
	output logic busy
);
	import flash_cmd_pkg::*;

	typedef enum {LS_OPCODE, LS_ID, LS_STATUS, LS_OTHER} link_state_t;

	// Link domain state; frame state reset asynchronously by chip select high, command toggle and synchronisers by resetn
	link_state_t lstate_q;
	logic [2:0] bit_cnt_q;
	logic [7:0] shift_q;
	logic [1:0] id_idx_q;
	logic [7:0] out_byte_q;
	logic so_q;
	logic cmd_tgl_q;
	cmd_info_t cmd_hold_q;
	logic [1:0] busy_sync_q;
	logic [2:0] cls_sync0_q;
	logic [2:0] cls_sync1_q;

	wire [7:0] opcode_w = {shift_q[6:0], si};
	wire opcode_done = (lstate_q == LS_OPCODE) && (bit_cnt_q == BIT_LAST);
	wire byte_done = (bit_cnt_q == BIT_LAST);
	wire link_busy = busy_sync_q[1];
	wire cmd_class_t link_busy_cls = cmd_class_t'(cls_sync1_q);

	// Identification bytes, one maker byte and no continuation codes
	// single maker byte
	wire [7:0] id_byte_w [ID_BYTES];
	assign id_byte_w[0] = MAKER_CODE;
	assign id_byte_w[1] = {FAMILY_CODE, DENSITY_CODE};
	assign id_byte_w[2] = {CELL_TECH, PRODUCT_VERSION};
	assign id_byte_w[3] = EXT_INFO_LEN;

	// Status byte: zero on top, ready flag in bit 6, device bits below
	// ready flag polarity
	wire [7:0] status_byte_w = {~link_busy, status_low};

	// Opcode class decode
	cmd_class_t dec_cls;
	logic dec_buf_two;
	logic dec_erase;
	always_comb begin
		dec_cls = CLS_NONE;
		dec_buf_two = 1'b0;
		dec_erase = 1'b0;
		case (opcode_w)
			OP_PAGE_READ, OP_CONT_LF, OP_CONT_HF, OP_CONT_LEGACY,
			OP_RD_PROT, OP_RD_LOCK, OP_RD_SECURITY:
				dec_cls = CLS_ARRAY_READ;
			OP_BUF1_RD_LF, OP_BUF1_RD, OP_BUF1_WRITE:
				dec_cls = CLS_BUFFER;
			OP_BUF2_RD_LF, OP_BUF2_RD, OP_BUF2_WRITE: begin
				dec_cls = CLS_BUFFER;
				dec_buf_two = 1'b1;
			end
			OP_STATUS, OP_ID_READ:
				dec_cls = CLS_BUFFER;
			OP_BUF1_PROG_ERASE: begin
				dec_cls = CLS_PROG_ERASE;
				dec_erase = 1'b1;
			end
			OP_BUF2_PROG_ERASE: begin
				dec_cls = CLS_PROG_ERASE;
				dec_erase = 1'b1;
				dec_buf_two = 1'b1;
			end
			OP_BUF1_PROG_NOERASE, OP_PROG_THRU_BUF1, OP_XFER_BUF1,
			OP_CMP_BUF1, OP_REWRITE_BUF1, OP_PAGE_ERASE,
			OP_BLOCK_ERASE, OP_SECTOR_ERASE, OP_CHIP_ERASE:
				dec_cls = CLS_PROG_ERASE;
			OP_BUF2_PROG_NOERASE, OP_PROG_THRU_BUF2, OP_XFER_BUF2,
			OP_CMP_BUF2, OP_REWRITE_BUF2: begin
				dec_cls = CLS_PROG_ERASE;
				dec_buf_two = 1'b1;
			end
			OP_PROT_PREFIX, OP_SECURITY_PROG:
				dec_cls = CLS_PROTECT;
			default:
				dec_cls = CLS_NONE;
		endcase
	end

	// Link input side: opcode shifting and byte counting on rising sck
	// chip select high resets link
	always_ff @(posedge sck or posedge cs_n) begin
		if (cs_n) begin
			lstate_q <= LS_OPCODE;
			bit_cnt_q <= 3'h0;
			shift_q <= 8'h00;
			id_idx_q <= 2'h0;
		end else begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
			shift_q <= opcode_w;
			case (lstate_q)
				LS_OPCODE: if (opcode_done) begin
					if (opcode_w == OP_ID_READ)
						lstate_q <= LS_ID;
					else if (opcode_w == OP_STATUS)
						lstate_q <= LS_STATUS;
					else
						lstate_q <= LS_OTHER;
				end
				LS_ID: if (byte_done && id_idx_q != ID_LAST)
					id_idx_q <= id_idx_q + 2'h1;
				LS_STATUS: ;
				LS_OTHER: ;
				default: lstate_q <= LS_OPCODE;
			endcase
		end
	end

	// Command toggle crosses into the core domain
	always_ff @(posedge sck or negedge resetn) begin
		if (!resetn) begin
			cmd_tgl_q <= 1'b0;
			cmd_hold_q <= '0;
		end else if (!cs_n && opcode_done) begin
			cmd_tgl_q <= ~cmd_tgl_q;
			cmd_hold_q <= '{opcode: opcode_w, cls: dec_cls,
				buf_two: dec_buf_two, erase_first: dec_erase};
		end
	end

	// Busy level and class synchronised into link domain
	always_ff @(posedge sck or negedge resetn) begin
		if (!resetn) begin
			busy_sync_q <= 2'b00;
			cls_sync0_q <= 3'h0;
			cls_sync1_q <= 3'h0;
		end else begin
			busy_sync_q <= {busy_sync_q[0], busy};
			cls_sync0_q <= 3'(cmd_info.cls);
			cls_sync1_q <= cls_sync0_q;
		end
	end

	// Output side: load byte and shift on falling sck
	wire load_byte = (bit_cnt_q == 3'h0);
	wire [7:0] next_byte = (lstate_q == LS_ID) ?
		id_byte_w[id_idx_q] : status_byte_w;
	wire out_active = (lstate_q == LS_ID) || (lstate_q == LS_STATUS);
	always_ff @(negedge sck or posedge cs_n) begin
		if (cs_n) begin
			out_byte_q <= 8'h00;
			so_q <= 1'b0;
		end else if (out_active) begin
			if (load_byte) begin
				so_q <= next_byte[7];
				out_byte_q <= {next_byte[6:0], 1'b0};
			end else begin
				so_q <= out_byte_q[7];
				out_byte_q <= {out_byte_q[6:0], 1'b0};
			end
		end
	end

	assign so = so_q;
	assign so_oe = !cs_n && out_active;

	// Core domain: toggle synchroniser and busy timer
	logic [2:0] tgl_sync_q;
	cmd_info_t cmd_q;
	logic cmd_valid_q;
	logic cmd_reject_q;
	logic busy_q;
	logic [$clog2(BUSY_CYCLES+1)-1:0] busy_cnt_q;
	wire tgl_edge = tgl_sync_q[2] ^ tgl_sync_q[1];
	wire cmd_info_t new_cmd = cmd_hold_q;
	wire allowed = !busy_q ||
		(cmd_q.cls == CLS_PROG_ERASE && new_cmd.cls == CLS_BUFFER) ||
		(cmd_q.cls == CLS_PROTECT && new_cmd.opcode == OP_STATUS);
	wire starts_timer = (new_cmd.cls == CLS_PROG_ERASE) ||
		(new_cmd.cls == CLS_PROTECT);

	always_ff @(posedge clk or negedge resetn) begin
		if (!resetn) begin
			tgl_sync_q <= 3'b000;
			cmd_q <= '0;
			cmd_valid_q <= 1'b0;
			cmd_reject_q <= 1'b0;
			busy_q <= 1'b0;
			busy_cnt_q <= '0;
		end else if (clk_en) begin
			tgl_sync_q <= {tgl_sync_q[1:0], cmd_tgl_q};
			cmd_valid_q <= tgl_edge && allowed;
			cmd_reject_q <= tgl_edge && !allowed;
			if (tgl_edge && allowed && starts_timer) begin
				cmd_q <= new_cmd;
				busy_q <= 1'b1;
				busy_cnt_q <= ($bits(busy_cnt_q))'(BUSY_CYCLES);
			end else if (busy_q) begin
				busy_cnt_q <= busy_cnt_q - 1'b1;
				if (busy_cnt_q == 1)
					busy_q <= 1'b0;
			end
		end
	end

	assign cmd_info = cmd_q;
	assign cmd_valid = cmd_valid_q;
	assign cmd_reject = cmd_reject_q;
	assign busy = busy_q;
endmodule

// File: tb/flash_cmd_chk_sva.sv
`timescale 1ns/1ns
module flash_cmd_chk
	import flash_cmd_pkg::*;
#(parameter int BUSY_CYCLES = 1000) (
	input wire logic clk, resetn, cs_n, so_oe, cmd_valid, cmd_reject, busy,
	input wire cmd_info_t cmd_info
);
	default clocking @(posedge clk); endclocking
	default disable iff (!resetn);
	sequence busy_start;
		$rose(busy);
	endsequence
	sequence busy_run;
		busy[*8];
	endsequence
	oe_release_a: assert property (cs_n ##1 cs_n |-> !so_oe)
		else $error("so_oe high while deselected");
	pulse_excl_a: assert property (!(cmd_valid && cmd_reject))
		else $error("accept and refuse together");
	valid_pulse_a: assert property (cmd_valid |=> !cmd_valid)
		else $error("cmd_valid longer than one cycle");
	reject_busy_a: assert property (cmd_reject |-> busy || $past(busy))
		else $error("refusal while idle");
	busy_hold_a: assert property (busy_start |-> busy_run)
		else $error("busy dropped early");
	erase_info_a: assert property (cmd_info.opcode == OP_BUF1_PROG_ERASE
		|-> cmd_info.erase_first && !cmd_info.buf_two)
		else $error("83H decode wrong");
	noerase_info_a: assert property (cmd_info.opcode == OP_BUF2_PROG_NOERASE
		|-> cmd_info.buf_two && !cmd_info.erase_first)
		else $error("89H decode wrong");
	thru_info_a: assert property (cmd_info.opcode == OP_PROG_THRU_BUF2
		|-> cmd_info.cls == CLS_PROG_ERASE && cmd_info.buf_two)
		else $error("85H decode wrong");
	prot_cls_a: assert property (cmd_info.opcode == OP_PROT_PREFIX
		|-> cmd_info.cls == CLS_PROTECT)
		else $error("3DH class wrong");
endmodule
bind flash_cmd_core flash_cmd_chk #(.BUSY_CYCLES(BUSY_CYCLES)) i_flash_cmd_chk (
	.clk(clk), .resetn(resetn), .cs_n(cs_n), .so_oe(so_oe),
	.cmd_valid(cmd_valid), .cmd_reject(cmd_reject), .busy(busy),
	.cmd_info(cmd_info));

// File: tb/flash_host.sv
`timescale 1ns/1ns
module flash_host (
	output logic sck, cs_n, si,
	input wire logic so, so_oe
);
	// Idle link: clock parked low, deselected
	initial begin
		sck = 1'b0;
		cs_n = 1'b1;
		si = 1'b0;
	end
	task automatic frame(input logic [7:0] op, input int n,
		output logic [39:0] rd);
		int i;
		rd = '0;
		cs_n = 1'b0;
		for (i = 0; i < 8 + n; i++) begin
			si = (i < 8) ? op[7 - i] : ~si; // Toggle after opcode
			#6 sck = 1'b1;
			if (i >= 8)
				rd = {rd[38:0], so_oe ? so : 1'bx};
			#6 sck = 1'b0;
		end
		#6 cs_n = 1'b1;
		#12;
	endtask
endmodule

// File: tb/serial_flash_id_and_command_groups_bench.sv
`timescale 1ns/1ns
module serial_flash_id_and_command_groups_bench;
	import flash_cmd_pkg::*;
	localparam int BUSY = 400;
	logic clk, resetn, clk_en, sck, cs_n, si, so, so_oe;
	logic cmd_valid, cmd_reject, busy, busy_q, busy_q2;
	logic [5:0] status_low;
	cmd_info_t cmd_info;
	logic [39:0] exp_q[$], got_q[$], rd, e, g, id;
	int num_errors, cmp_count, rejects, r0, i, k;
	int seed = 32'hFD3E;
	logic [7:0] tl[15] = '{8'h83, 8'h86, 8'h88, 8'h89, 8'h82, 8'h85,
		8'h81, 8'h50, 8'h7C, 8'h53, 8'h55, 8'h60, 8'h61, 8'h58, 8'h59};
	logic [8:0] rl[13] = '{9'h1D2, 9'h103, 9'h10B, 9'h1E8, 9'h132,
		9'h135, 9'h177, 9'h0D1, 9'h0D3, 9'h0D4, 9'h0D6, 9'h084, 9'h087};
	flash_cmd_core #(.BUSY_CYCLES(BUSY)) i_flash_cmd_core (.clk(clk),
		.resetn(resetn), .clk_en(clk_en), .sck(sck), .cs_n(cs_n),
		.si(si), .so(so), .so_oe(so_oe), .status_low(status_low),
		.cmd_info(cmd_info), .cmd_valid(cmd_valid),
		.cmd_reject(cmd_reject), .busy(busy));
	flash_host i_flash_host (.sck(sck), .cs_n(cs_n), .si(si), .so(so),
		.so_oe(so_oe));
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end
	// Collect results and compare with the oldest note
	always @(posedge clk) begin
		busy_q <= busy;
		busy_q2 <= busy_q;
		if (cmd_reject === 1'b1)
			rejects++;
		if (busy_q === 1'b1 && busy_q2 === 1'b0)
			got_q.push_back(40'({cmd_info.cls, cmd_info.opcode}));
		if (got_q.size() > 0) begin
			e = exp_q.pop_front();
			g = got_q.pop_front();
			cmp_count++;
			if (g !== e) begin
				num_errors++;
				$display("mismatch at %0t exp %0h got %0h", $time, e, g);
			end
		end
	end
	task automatic end_of_test();
		if (num_errors == 0 && cmp_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic rd_frame(input logic [7:0] op, input int n);
		@(posedge clk) #1;
		i_flash_host.frame(op, n, rd);
		got_q.push_back(rd);
	endtask
	task automatic wait_idle();
		for (k = 0; k < 3000 && busy !== 1'b0; k++)
			@(posedge clk);
		if (busy !== 1'b0)
			num_errors++;
	endtask
	// Watchdog
	initial begin
		#200000;
		num_errors++;
		end_of_test();
	end
	initial begin
		resetn = 1'b0;
		clk_en = 1'b1;
		status_low = '0;
		repeat (5) @(posedge clk);
		#1 resetn = 1'b1;
		id = {MAKER_CODE, FAMILY_CODE, DENSITY_CODE, CELL_TECH,
			PRODUCT_VERSION, EXT_INFO_LEN};
		exp_q.push_back({id[31:0], 8'h00});
		rd_frame(OP_ID_READ, 40);
		exp_q.push_back(40'(MAKER_CODE[7:4]));
		rd_frame(OP_ID_READ, 4);
		exp_q.push_back(id);
		rd_frame(OP_ID_READ, 32);
		@(posedge clk) #1 status_low = 6'($random(seed));
		exp_q.push_back(40'({2'h1, status_low, 2'h1, status_low}));
		rd_frame(OP_STATUS, 16);
		for (i = 0; i < 15; i++) begin
			wait_idle();
			exp_q.push_back(40'({CLS_PROG_ERASE, tl[i]}));
			rd_frame(tl[i], 0);
			void'(got_q.pop_back());
			for (k = 0; i == 0 && k < 13; k++) begin
				r0 = rejects;
				i_flash_host.frame(rl[k][7:0], 0, rd);
				repeat (8) @(posedge clk);
				exp_q.push_back(40'(rl[k][8]));
				got_q.push_back(40'(rejects - r0));
			end
			if (i == 0)
				exp_q.push_back(40'({2'h0, status_low}));
			if (i == 0)
				rd_frame(OP_STATUS, 8);
		end
		wait_idle();
		exp_q.push_back(40'({CLS_PROTECT, OP_PROT_PREFIX}));
		rd_frame(OP_PROT_PREFIX, 0);
		void'(got_q.pop_back());
		r0 = rejects;
		i_flash_host.frame(OP_BUF1_RD, 0, rd);
		repeat (8) @(posedge clk);
		exp_q.push_back(40'h1);
		got_q.push_back(40'(rejects - r0));
		exp_q.push_back(40'({2'h0, status_low}));
		rd_frame(OP_STATUS, 8);
		wait_idle();
		repeat (4) @(posedge clk);
		if (exp_q.size() != 0)
			num_errors++;
		end_of_test();
	end
endmodule
